// ===== src/sbrs_pkg.sv
// Package for the supply brownout and reset sequencer.
// Assumes a single 250 MHz core clock and digitised comparator levels.
package sbrs_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;                 // Core clock rate
    localparam int RC_KHZ = 7600;                 // Internal RC oscillator rate
    localparam int PWRUP_US_X10 = 86000;          // Power-up delay, 8.6 ms in tenths of a microsecond
    // Core clocks per RC tick, rounded down (the RC tick is an enable pulse)
    localparam int RC_DIV = (CLK_MHZ * 1000) / RC_KHZ;
    // RC ticks in the power-up delay, rounded up
    // Tenths of a microsecond times kilohertz gives ticks times 10000
    localparam int PWRUP_TICKS = (PWRUP_US_X10 * RC_KHZ + 9999) / 10000;
    localparam int RC_DIV_W = 6;
    localparam int PWRUP_W = 17;

    // ----------------------------------------
    // Threshold fields
    // ----------------------------------------
    localparam int SEL_W = 2;                     // Width of each threshold selection
    localparam logic [1:0] CORE_RESET_SEL_POR = 2'h0; // Lowest reset band after power-on
    localparam logic [1:0] CORE_WARN_SEL_POR = 2'h0;
    localparam logic [1:0] IO_WARN_SEL_POR = 2'h0;
    localparam logic [15:0] RESET_VECTOR = 16'h8000; // Fixed start address in utility ROM

    // Sequencer states
    typedef enum logic [2:0] {
        SBRS_OFF    = 3'b000,  // Below the power-on reset level
        SBRS_POR    = 3'b001,  // Power-on reset held, waiting for reset level
        SBRS_COUNT  = 3'b010,  // Power-up counter running
        SBRS_RUN    = 3'b011,  // Reset released
        SBRS_BROWN  = 3'b100   // Brownout reset held
    } sbrs_state_type;
endpackage

// ===== src/sbrs_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes the destination is the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module sbrs_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,      // Core clock
    input wire logic i_rst_b,         // Async reset, active low
    input wire logic [W-1:0] i_async, // Asynchronous levels
    output logic [W-1:0] o_sync       // Synchronised levels
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== src/sbrs_seq.sv
// Supply brownout and reset sequencer: watches supply comparators,
// raises warning interrupts and runs the open-drain reset pin.
// Assumes comparator outputs are asynchronous levels, high when the supply
// is above the level named; analog selection follows the *_sel outputs.
//
// Contract
// RULE1: An I/O supply below the selected I/O warning threshold raises an interrupt.
// RULE2: A core supply below the selected core warning threshold raises a warning interrupt ahead of reset.
// RULE3: Once the core supply is above the lowest detection level the reset pin is driven low.
// RULE4: Passing the power-on reset level loads every register with its power-on default.
// RULE5: Power-on reset clears the core reset threshold selection to zero.
// RULE6: Above the reset threshold after power-up an RC-clocked counter runs the power-up delay, then the pin is released.
// RULE7: After a valid power-up release the processor starts at the fixed reset vector.
// RULE8: Software writes the three threshold selections after release and later comparisons use them.
// RULE9: Core supply below the reset threshold pulls the pin low, halts activity and resets most registers.
// RULE10: The core reset threshold selection survives a brownout reset above the power-on level.
// RULE11: While the core supply stays below the reset threshold the pin and processor stay in reset.
// RULE12: Recovery above the reset threshold without power-on releases at once with brownout defaults.
// RULE13: Falling below the power-on level resets everything and a full power-up follows.
// RULE14: The reset pin is active-low open drain, may be pulled low outside, and the device drives it in reset.
// RULE15: Each warning sets its own sticky flag that software clears.
`timescale 1ns/1ns
`default_nettype none
module sbrs_seq #(
    // Power-up delay in RC ticks; a shorter value keeps simulation runs short
    parameter int PWRUP_TICKS = sbrs_pkg::PWRUP_TICKS
) (
    input wire logic i_core_clk,            // Core clock, 250 MHz
    input wire logic i_rst_b,               // Async reset, active low
    input wire logic i_core_above_detect,   // Core supply above lowest detection level
    input wire logic i_core_above_por,      // Core supply above power-on reset level
    input wire logic i_core_above_reset,    // Core supply above selected reset threshold
    input wire logic i_core_above_warn,     // Core supply above selected warning threshold
    input wire logic i_io_above_warn,       // I/O supply above selected warning threshold
    input wire logic i_reset_pin,           // Level seen on the reset pin
    input wire logic i_sel_wr,              // Processor writes threshold selections
    input wire logic [1:0] i_core_warn_sel_wr,  // New core warning selection
    input wire logic [1:0] i_io_warn_sel_wr,    // New I/O warning selection
    input wire logic [1:0] i_core_reset_sel_wr, // New core reset selection
    input wire logic i_core_warn_clr,       // Processor clears core warning flag
    input wire logic i_io_warn_clr,         // Processor clears I/O warning flag
    output logic o_reset_pin_out,           // Reset pin output value, always low
    output logic o_reset_pin_oe,            // Reset pin driven low when high
    output logic o_cpu_reset_b,             // Processor and peripheral reset, active low
    output logic o_por_defaults,            // Registers take power-on defaults
    output logic o_bor_defaults,            // Registers take brownout defaults
    output logic [15:0] o_start_vector,     // Address the processor starts at
    output logic [1:0] o_core_warn_sel,     // Core warning threshold selection
    output logic [1:0] o_io_warn_sel,       // I/O warning threshold selection
    output logic [1:0] o_core_reset_sel,    // Core reset threshold selection
    output logic o_core_warn_flag,          // Sticky core warning flag
    output logic o_io_warn_flag,            // Sticky I/O warning flag
    output logic o_supply_warning_interrupt // Warning interrupt to the processor
);
    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [5:0] sync;
    logic core_detect;
    logic core_por;
    logic core_rst_ok;
    logic core_warn_ok;
    logic io_warn_ok;
    logic pin_level;

    // Comparator outputs and the pin come from outside the clock domain
    sbrs_sync #(.W(6)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_core_above_detect, i_core_above_por, i_core_above_reset,
                  i_core_above_warn, i_io_above_warn, i_reset_pin}),
        .o_sync(sync)
    );
    assign {core_detect, core_por, core_rst_ok, core_warn_ok, io_warn_ok, pin_level} = sync;

    // ----------------------------------------
    // RC tick divider and power-up counter
    // ----------------------------------------
    sbrs_pkg::sbrs_state_type state;
    sbrs_pkg::sbrs_state_type next_state;
    logic [5:0] rc_div;
    logic rc_tick;
    logic [16:0] pwrup_cnt;
    logic pwrup_done;

    // RC oscillator rate as a one-cycle enable
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rc_div <= 6'h00;
            rc_tick <= 1'b0;
        end else if (rc_div == 6'(sbrs_pkg::RC_DIV - 1)) begin
            rc_div <= 6'h00;
            rc_tick <= 1'b1;
        end else begin
            rc_div <= rc_div + 6'h01;
            rc_tick <= 1'b0;
        end
    end

    // Counter runs only in the count state; any other state rewinds it
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwrup_cnt <= 17'h00000;
        end else if (state != sbrs_pkg::SBRS_COUNT) begin
            pwrup_cnt <= 17'h00000;
        end else if (rc_tick && !pwrup_done) begin
            pwrup_cnt <= pwrup_cnt + 17'h00001; // see RULE6
        end
    end
    assign pwrup_done = (pwrup_cnt == 17'(PWRUP_TICKS));

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Power-on level loss always wins, so recovery repeats the full power-up
    always_comb begin
        next_state = state;
        if (!core_por) begin
            next_state = sbrs_pkg::SBRS_OFF; // see RULE13
        end else begin
            unique case (state)
                sbrs_pkg::SBRS_OFF: begin
                    next_state = sbrs_pkg::SBRS_POR;
                end
                sbrs_pkg::SBRS_POR: begin
                    if (core_rst_ok) begin
                        next_state = sbrs_pkg::SBRS_COUNT; // see RULE6
                    end
                end
                sbrs_pkg::SBRS_COUNT: begin
                    if (!core_rst_ok) begin
                        next_state = sbrs_pkg::SBRS_POR;
                    end else if (pwrup_done) begin
                        next_state = sbrs_pkg::SBRS_RUN; // see RULE6
                    end
                end
                sbrs_pkg::SBRS_RUN: begin
                    if (!core_rst_ok) begin
                        next_state = sbrs_pkg::SBRS_BROWN; // see RULE9
                    end
                end
                sbrs_pkg::SBRS_BROWN: begin
                    if (core_rst_ok) begin
                        next_state = sbrs_pkg::SBRS_RUN; // see RULE12
                    end
                end
                default: begin
                    next_state = sbrs_pkg::SBRS_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= sbrs_pkg::SBRS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Reset pin and processor reset
    // ----------------------------------------
    // Open drain: only ever drives low; an outside low also resets the processor
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reset_pin_out <= 1'b0;
            o_reset_pin_oe <= 1'b0;
            o_cpu_reset_b <= 1'b0;
            o_por_defaults <= 1'b1;
            o_bor_defaults <= 1'b0;
            o_start_vector <= sbrs_pkg::RESET_VECTOR;
        end else begin
            o_reset_pin_out <= 1'b0; // see RULE14
            // Below the detection level the pin cannot be driven at all
            o_reset_pin_oe <= core_detect && (next_state != sbrs_pkg::SBRS_RUN); // see RULE3, RULE11
            o_cpu_reset_b <= (next_state == sbrs_pkg::SBRS_RUN) && pin_level; // see RULE14, RULE11
            // Power-on defaults hold until the power-up delay has run out
            o_por_defaults <= (next_state == sbrs_pkg::SBRS_OFF) ||
                              (next_state == sbrs_pkg::SBRS_POR) ||
                              (next_state == sbrs_pkg::SBRS_COUNT); // see RULE4
            o_bor_defaults <= (next_state == sbrs_pkg::SBRS_BROWN); // see RULE9
            o_start_vector <= sbrs_pkg::RESET_VECTOR; // see RULE7, RULE12
        end
    end

    // ----------------------------------------
    // Threshold selections
    // ----------------------------------------
    // Warning selections take defaults whenever the sequencer is out of run; an outside pin low leaves them
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_warn_sel <= sbrs_pkg::CORE_WARN_SEL_POR;
            o_io_warn_sel <= sbrs_pkg::IO_WARN_SEL_POR;
        end else if (next_state != sbrs_pkg::SBRS_RUN || state != sbrs_pkg::SBRS_RUN) begin
            o_core_warn_sel <= sbrs_pkg::CORE_WARN_SEL_POR; // see RULE9
            o_io_warn_sel <= sbrs_pkg::IO_WARN_SEL_POR;
        end else if (i_sel_wr) begin
            o_core_warn_sel <= i_core_warn_sel_wr; // see RULE8
            o_io_warn_sel <= i_io_warn_sel_wr;
        end
    end

    // Reset selection survives brownout so recovery uses the programmed band
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_reset_sel <= sbrs_pkg::CORE_RESET_SEL_POR;
        end else if (next_state == sbrs_pkg::SBRS_OFF) begin
            o_core_reset_sel <= sbrs_pkg::CORE_RESET_SEL_POR; // see RULE5, RULE13
        end else if (i_sel_wr && state == sbrs_pkg::SBRS_RUN && next_state == sbrs_pkg::SBRS_RUN) begin
            o_core_reset_sel <= i_core_reset_sel_wr; // see RULE8, RULE10
        end
    end

    // ----------------------------------------
    // Warning flags and interrupt
    // ----------------------------------------
    logic run_now;
    assign run_now = (state == sbrs_pkg::SBRS_RUN) && (next_state == sbrs_pkg::SBRS_RUN);

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_warn_flag <= 1'b0;
            o_io_warn_flag <= 1'b0;
        end else if (!run_now) begin
            o_core_warn_flag <= 1'b0;
            o_io_warn_flag <= 1'b0;
        end else begin
            o_core_warn_flag <= !core_warn_ok || (o_core_warn_flag && !i_core_warn_clr); // see RULE2, RULE15
            o_io_warn_flag <= !io_warn_ok || (o_io_warn_flag && !i_io_warn_clr); // see RULE1, RULE15
        end
    end

    // Interrupt follows the flags one cycle later
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_supply_warning_interrupt <= 1'b0;
        end else begin
            o_supply_warning_interrupt <= o_core_warn_flag || o_io_warn_flag; // see RULE1, RULE2
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_IO_WARN_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE1
        run_now && !io_warn_ok |=> o_io_warn_flag ##1 o_supply_warning_interrupt)
        else $error("I/O warning did not reach the interrupt");
    AST_CORE_WARN_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE2
        run_now && !core_warn_ok |=> o_core_warn_flag ##1 o_supply_warning_interrupt)
        else $error("Core warning did not reach the interrupt");
    AST_PIN_LOW_IN_POR: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE3
        core_detect && state == sbrs_pkg::SBRS_POR |=> o_reset_pin_oe)
        else $error("Reset pin not driven during power-up");
    AST_RESET_SEL_POR: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE5
        next_state == sbrs_pkg::SBRS_OFF |=> o_core_reset_sel == 2'h0)
        else $error("Reset selection not cleared on power-on");
    AST_NO_EARLY_RELEASE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE6
        state == sbrs_pkg::SBRS_COUNT && next_state == sbrs_pkg::SBRS_RUN |-> pwrup_done)
        else $error("Released before power-up delay");
    AST_BROWN_PIN: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE9
        state == sbrs_pkg::SBRS_RUN && !core_rst_ok && core_por |=> o_reset_pin_oe && !o_cpu_reset_b)
        else $error("Brownout did not assert reset");
    AST_KEEP_RESET_SEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE10
        state == sbrs_pkg::SBRS_BROWN && core_por |=> $stable(o_core_reset_sel))
        else $error("Reset selection lost in brownout");
    AST_FAST_RECOVER: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE12
        state == sbrs_pkg::SBRS_BROWN && core_rst_ok && core_por |=> state == sbrs_pkg::SBRS_RUN)
        else $error("Brownout recovery was delayed");
    AST_POR_LOSS: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // see RULE13
        !core_por |=> state == sbrs_pkg::SBRS_OFF && o_por_defaults)
        else $error("Power-on loss did not reset");
endmodule
`default_nettype wire

// ===== test/sbrs_supply_model.sv
// Behavioural supply comparators and reset pin wire for the sequencer bench.
// Assumes the bench sets both supplies in millivolts and the far party's pull.
`timescale 1ns/1ns
`default_nettype none
module sbrs_supply_model #(
    parameter int DETECT_MV = 1000,
    parameter int POR_MV = 1200
) (
    input wire logic [15:0] i_core_mv,       // Core supply level
    input wire logic [15:0] i_io_mv,         // I/O supply level
    input wire logic [1:0] i_core_warn_sel,  // Core warning selection
    input wire logic [1:0] i_io_warn_sel,    // I/O warning selection
    input wire logic [1:0] i_core_reset_sel, // Core reset selection
    input wire logic i_pin_out,              // Pin output value
    input wire logic i_pin_oe,               // Pin drive enable
    input wire logic i_ext_low,              // Outside party pulls pin low
    output logic o_core_above_detect,        // Core above detection level
    output logic o_core_above_por,           // Core above power-on level
    output logic o_core_above_reset,         // Core above reset band
    output logic o_core_above_warn,          // Core above warning band
    output logic o_io_above_warn,            // I/O above warning band
    output logic o_reset_pin                 // Resolved pin level
);
    // ----------------------------------------
    // Threshold bands
    // ----------------------------------------
    // One plain pick per band; warning bands sit above reset bands
    localparam int RESET_MV [4] = '{2850, 2950, 3050, 3150};
    localparam int CORE_WARN_MV [4] = '{3100, 3150, 3200, 3250};
    localparam int IO_WARN_MV [4] = '{4500, 4600, 4700, 4800};

    // Comparators follow whatever selection the sequencer presents
    assign o_core_above_detect = (int'(i_core_mv) > DETECT_MV);
    assign o_core_above_por = (int'(i_core_mv) > POR_MV);
    assign o_core_above_reset = (int'(i_core_mv) > RESET_MV[i_core_reset_sel]);
    assign o_core_above_warn = (int'(i_core_mv) > CORE_WARN_MV[i_core_warn_sel]);
    assign o_io_above_warn = (int'(i_io_mv) > IO_WARN_MV[i_io_warn_sel]);

    // Open-drain wire with weak pull-up: low if anyone drives it
    assign o_reset_pin = !((i_pin_oe && !i_pin_out) || i_ext_low);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the supply brownout and reset sequencer.
// Assumes the supply model above; the power-up delay is shortened for the run.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam int TB_TICKS = 200; // Shortened power-up delay in RC ticks
    localparam int EXP_CYCLES = TB_TICKS * sbrs_pkg::RC_DIV;
    localparam int LIMIT = EXP_CYCLES + EXP_CYCLES / 10;
    logic i_core_clk, i_rst_b, sel_wr, cw_clr, iw_clr, ext_low, pin;
    logic det, por, rst_ok, cw_ok, iw_ok, pin_out, oe, cpu_b, por_d, bor_d, cw_f, iw_f, irq;
    logic [1:0] cw_wr, iw_wr, cr_wr, cw_sel, iw_sel, cr_sel;
    logic [15:0] core_mv, io_mv, vec;
    int fails = 0;
    int check_count = 0;

    sbrs_seq #(.PWRUP_TICKS(TB_TICKS)) sbrs_seq_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_core_above_detect(det),
        .i_core_above_por(por), .i_core_above_reset(rst_ok), .i_core_above_warn(cw_ok),
        .i_io_above_warn(iw_ok), .i_reset_pin(pin), .i_sel_wr(sel_wr), .i_core_warn_sel_wr(cw_wr),
        .i_io_warn_sel_wr(iw_wr), .i_core_reset_sel_wr(cr_wr), .i_core_warn_clr(cw_clr),
        .i_io_warn_clr(iw_clr), .o_reset_pin_out(pin_out), .o_reset_pin_oe(oe), .o_cpu_reset_b(cpu_b),
        .o_por_defaults(por_d), .o_bor_defaults(bor_d), .o_start_vector(vec), .o_core_warn_sel(cw_sel),
        .o_io_warn_sel(iw_sel), .o_core_reset_sel(cr_sel), .o_core_warn_flag(cw_f),
        .o_io_warn_flag(iw_f), .o_supply_warning_interrupt(irq));

    sbrs_supply_model sbrs_supply_model_inst (.i_core_mv(core_mv), .i_io_mv(io_mv),
        .i_core_warn_sel(cw_sel), .i_io_warn_sel(iw_sel), .i_core_reset_sel(cr_sel),
        .i_pin_out(pin_out), .i_pin_oe(oe), .i_ext_low(ext_low), .o_core_above_detect(det),
        .o_core_above_por(por), .o_core_above_reset(rst_ok), .o_core_above_warn(cw_ok),
        .o_io_above_warn(iw_ok), .o_reset_pin(pin));

    // 250 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare and count; four-state compare so unknowns never match
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs move only at falling edges; 8 cycles covers sync plus flag plus interrupt
    task automatic settle(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up();
        int cnt;
        cnt = 0;
        check(16'(sbrs_pkg::PWRUP_TICKS), 16'hFF50);
        core_mv = 16'h044C; // Between detection and power-on levels
        settle(8);
        check(oe, 1'b1);
        check(cpu_b, 1'b0);
        core_mv = 16'h0CE4; // Nominal core supply
        settle(8);
        check(cr_sel, 2'h0);
        check(por_d, 1'b1);
        while (oe === 1'b1 && cnt < LIMIT) begin
            settle(1);
            cnt++;
        end
        // Typical figure, so allow five percent under and ten percent over
        check(cnt > EXP_CYCLES - EXP_CYCLES / 20 && cnt < LIMIT, 1'b1);
        settle(8);
        check(cpu_b, 1'b1);
        check(vec, 16'h8000);
        $display("test power_up done");
    endtask

    task automatic t_select_warn();
        sel_wr = 1'b1;
        cw_wr = 2'h2;
        iw_wr = 2'h1;
        cr_wr = 2'h1;
        settle(1);
        sel_wr = 1'b0;
        settle(2);
        check({cw_sel, iw_sel, cr_sel}, 6'h25);
        core_mv = 16'h0C94; // Above the new warning band only
        settle(8);
        check(cw_f, 1'b0);
        core_mv = 16'h0C1C; // Below warning, above reset band
        settle(8);
        check({cw_f, iw_f, irq, cpu_b}, 4'hB);
        core_mv = 16'h0CE4;
        settle(8);
        check(cw_f, 1'b1);
        cw_clr = 1'b1;
        settle(1);
        cw_clr = 1'b0;
        settle(8);
        check({cw_f, irq}, 2'h0);
        io_mv = 16'h11C6; // Only below the selected I/O band
        settle(8);
        check({iw_f, cw_f, irq}, 3'h5);
        io_mv = 16'h1388;
        settle(8);
        check(iw_f, 1'b1);
        iw_clr = 1'b1;
        settle(1);
        iw_clr = 1'b0;
        settle(8);
        check({iw_f, irq}, 2'h0);
        $display("test select_warn done");
    endtask

    task automatic t_brownout();
        core_mv = 16'h0B54; // Under reset band 1, above power-on level
        settle(8);
        check({oe, cpu_b, bor_d}, 3'h5);
        check(cw_sel, 2'h0);
        settle(50);
        check({oe, cpu_b}, 2'h2);
        check(cr_sel, 2'h1);
        core_mv = 16'h0CE4;
        settle(8);
        check({oe, cpu_b, bor_d}, 3'h2);
        check(vec, 16'h8000);
        $display("test brownout done");
    endtask

    task automatic t_ext_hold();
        ext_low = 1'b1;
        settle(8);
        check({oe, cpu_b}, 2'h0);
        ext_low = 1'b0;
        settle(8);
        check(cpu_b, 1'b1);
        $display("test ext_hold done");
    endtask

    task automatic t_por_loss();
        core_mv = 16'h01F4; // Under the power-on level
        settle(8);
        check(cr_sel, 2'h0);
        core_mv = 16'h0CE4;
        settle(200);
        // Full delay again, so still held long after a brownout release
        check({oe, cpu_b, por_d}, 3'h5);
        $display("test por_loss done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        {i_rst_b, sel_wr, cw_clr, iw_clr, ext_low} = 5'h0;
        {cw_wr, iw_wr, cr_wr} = 6'h0;
        core_mv = 16'h0000;
        io_mv = 16'h1388;
        settle(16);
        check(por_d, 1'b1);
        i_rst_b = 1'b1;
        settle(4);
        t_power_up();
        t_select_warn();
        t_brownout();
        t_ext_hold();
        t_por_loss();
        print_verdict();
    end

    // Span is the full power-up delay plus slack for the short tests
    initial begin
        repeat (LIMIT + 20000) @(posedge i_core_clk);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
